// ==== logic/payload_tributary_mapper.sv ====
`timescale 1ns/1ns
`include "ptm_regs.svh"

module payload_tributary_mapper #(
    parameter int ACC_N = 5
) (
    // clock and reset
    input  wire logic                      i_clk,
    input  wire logic                      i_rst_n,
    // static configuration
    input  wire ptm_pkg::map_mode_e        i_mode,
    input  wire logic [5:0]                i_clr_octets,
    input  wire logic [2:0]                i_clr_zbits,
    input  wire logic [5:0]                i_frac_octets,
    input  wire logic [2:0]                i_num_access,
    input  wire logic                      i_err_clear,
    // line frame builder slot requests
    input  wire logic                      i_slot_req,
    input  wire logic                      i_block_start,
    // serial tributary
    input  wire logic                      i_trib_bit,
    input  wire logic                      i_trib_frame_start,
    // isdn access channels, sampled at block start
    input  wire logic [ACC_N-1:0][7:0]     i_isdn_b1,
    input  wire logic [ACC_N-1:0][7:0]     i_isdn_b2,
    input  wire logic [ACC_N-1:0][1:0]     i_isdn_d,
    // payload out and status
    output logic                           o_pay_bit,
    output logic                           o_pay_valid,
    output logic [5:0]                     o_cfg_octets,
    output logic [2:0]                     o_cfg_zbits,
    output logic                           o_cfg_err,
    output logic                           o_align_err
);
    import ptm_pkg::*;

    localparam int POS_W = 9;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        map_mode_e                  mode;
        logic [2:0]                 num;
        logic [5:0]                 oct;
        logic [2:0]                 zb;
        logic                       cfg_err;
        logic [POS_W-1:0]           pos;
        logic [ACC_N-1:0][7:0]      b1;
        logic [ACC_N-1:0][7:0]      b2;
        logic [ACC_N-1:0][1:0]      d_pend;
        logic [ACC_N-1:0][1:0]      d_cur;
        logic                       off_known;
        logic [POS_W-1:0]           off;
        logic                       align_err;
        logic                       pay_bit;
        logic                       pay_valid;
    } mapper_s;

    mapper_s st;
    mapper_s next_st;
    logic                  bstart;
    logic [POS_W-1:0]      cur_pos;
    logic [POS_W-1:0]      oct_off;
    logic [2:0]            zb_use;
    logic [2:0]            num_use;
    logic [5:0]            oct_use;
    logic [5:0]            n_new;
    logic [2:0]            z_new;
    logic                  err_new;
    logic [ACC_N-1:0][7:0] b1_src;
    logic [ACC_N-1:0][7:0] b2_src;
    logic [ACC_N-1:0][1:0] d_src;
    logic [2:0]            acc;
    logic                  isdn_bit;
    logic                  set_err;

    if (ACC_N < 1 || ACC_N > int'(`PTM_ACC_MAX)) begin : g_acc_check
        $error("ACC_N must lie in 1..5");
    end

    // ------------------------------------------------------------
    // configuration decode
    // ------------------------------------------------------------
    // slot counts from the mode, and in isdn mode from the number of accesses
    always_comb begin
        n_new   = `PTM_OCT_STRUCT;
        z_new   = '0;
        err_new = 1'b0;
        unique case (i_mode)
            // clear channel uses the configured counts
            MODE_CLEAR: begin
                n_new   = i_clr_octets;
                z_new   = i_clr_zbits;
                err_new = i_clr_octets < `PTM_OCT_MIN ||
                          i_clr_octets > `PTM_OCT_MAX;
            end
            MODE_UNALIGNED: n_new = `PTM_OCT_STRUCT;
            // full or fractional, no single bits
            MODE_ALIGNED: begin
                n_new   = i_frac_octets;
                err_new = i_frac_octets < `PTM_OCT_MIN ||
                          i_frac_octets > `PTM_OCT_STRUCT;
            end
            MODE_ISDN: begin
                unique case (i_num_access)
                    3'h1: begin
                        n_new = `PTM_ISDN_OCT1;
                        z_new = `PTM_ISDN_Z1;
                    end
                    3'h2: begin
                        n_new = `PTM_ISDN_OCT2;
                        z_new = `PTM_ISDN_Z2;
                    end
                    3'h3: begin
                        n_new = `PTM_ISDN_OCT3;
                        z_new = `PTM_ISDN_Z3;
                    end
                    3'h4: begin
                        n_new = `PTM_ISDN_OCT4;
                        z_new = `PTM_ISDN_Z4;
                    end
                    3'h5: begin
                        n_new = `PTM_ISDN_OCT5;
                        z_new = `PTM_ISDN_Z5;
                    end
                    default: begin
                        n_new   = '0;
                        err_new = 1'b1;
                    end
                endcase
                if (i_num_access > 3'(ACC_N))
                    err_new = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------
    // isdn slot selection
    // ------------------------------------------------------------
    // b1 and b2 sources switch to fresh samples in the block start cycle
    always_comb begin
        bstart  = i_slot_req & i_block_start;
        cur_pos = bstart ? '0 : st.pos;
        zb_use  = bstart ? z_new : st.zb;
        num_use = bstart ? i_num_access : st.num;
        oct_use = bstart ? n_new : st.oct;
        oct_off = cur_pos - POS_W'(zb_use);
        b1_src  = bstart ? i_isdn_b1 : st.b1;
        b2_src  = bstart ? i_isdn_b2 : st.b2;
        // d bits used now were sampled one block earlier
        d_src   = bstart ? st.d_pend : st.d_cur;
        acc      = '0;
        isdn_bit = 1'b0;
        // single bits first, then octet slots
        if (cur_pos < POS_W'(zb_use)) begin
            // each pair of single bits belongs to one access, in access order
            acc = 3'(cur_pos[2:1]);
            if (acc < num_use && acc < 3'(ACC_N))
                isdn_bit = d_src[acc][~cur_pos[0]];
        end else if (oct_off < POS_W'({oct_use, 3'h0})) begin
            if (num_use < `PTM_SHARED_MIN) begin
                // access k in octets 2k-1 and 2k
                acc = 3'(oct_off[8:4]);
                if (acc < 3'(ACC_N))
                    isdn_bit = oct_off[3] ? b2_src[acc][~oct_off[2:0]]
                                          : b1_src[acc][~oct_off[2:0]];
            end else if (oct_off[8:3] == 6'h00) begin
                // octet 1 holds four d channels
                // bits 2k-1 and 2k belong to access k, or to access k+1 with five accesses
                acc = 3'(oct_off[2:1]) +
                      ((num_use == `PTM_SHARED_MIN) ? 3'h0 : 3'h1);
                if (acc < 3'(ACC_N))
                    isdn_bit = d_src[acc][~oct_off[0]];
            end else begin
                // access k in octets 2k and 2k+1
                acc = 3'((oct_off[8:3] - 6'h01) >> 1);
                if (acc < 3'(ACC_N))
                    isdn_bit = oct_off[3] ? b1_src[acc][~oct_off[2:0]]
                                          : b2_src[acc][~oct_off[2:0]];
            end
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        set_err = 1'b0;
        next_st.pay_valid = i_slot_req;
        // configuration latched only at block start
        if (bstart) begin
            next_st.mode    = i_mode;
            next_st.num     = i_num_access;
            next_st.oct     = n_new;
            next_st.zb      = z_new;
            next_st.cfg_err = err_new;
            next_st.b1      = i_isdn_b1;
            next_st.b2      = i_isdn_b2;
            next_st.d_pend  = i_isdn_d;
            next_st.d_cur   = st.d_pend;
            if (i_mode != st.mode)
                next_st.off_known = 1'b0;
        end
        if (i_slot_req) begin
            next_st.pos = cur_pos + POS_W'(1);
            // stream modes pass bits in arrival order
            // isdn payload carries only b and d bits
            next_st.pay_bit = (st.mode == MODE_ISDN && !bstart) ||
                              (bstart && i_mode == MODE_ISDN)
                              ? isdn_bit : i_trib_bit;
            // aligned frame must start at block bit 0
            if ((bstart ? i_mode : st.mode) == MODE_ALIGNED &&
                i_trib_frame_start != (cur_pos == '0))
                set_err = 1'b1;
            // unaligned frame start offset must not move
            if ((bstart ? i_mode : st.mode) == MODE_UNALIGNED &&
                i_trib_frame_start) begin
                if (!next_st.off_known) begin
                    next_st.off_known = 1'b1;
                    next_st.off       = cur_pos;
                end else if (st.off != cur_pos) begin
                    set_err = 1'b1;
                end
            end
        end
        // set wins over clear
        if (set_err)
            next_st.align_err = 1'b1;
        else if (i_err_clear)
            next_st.align_err = 1'b0;
    end

    // state register, one clock for all channels
    always_ff @(posedge i_clk) begin
        if (!i_rst_n)
            st <= '0;
        else
            st <= next_st;
    end

    // outputs straight from state
    assign o_pay_bit    = st.pay_bit;
    assign o_pay_valid  = st.pay_valid;
    assign o_cfg_octets = st.oct;
    assign o_cfg_zbits  = st.zb;
    assign o_cfg_err    = st.cfg_err;
    assign o_align_err  = st.align_err;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    property p_stream_order;
        i_slot_req && !bstart && st.mode != MODE_ISDN
        |=> o_pay_valid && o_pay_bit == $past(i_trib_bit);
    endproperty
    a_stream_order: assert property (p_stream_order)
        else $error("stream bit not passed in order");
    property p_unaligned_cfg;
        st.mode == MODE_UNALIGNED |-> o_cfg_octets == `PTM_OCT_STRUCT &&
                                      o_cfg_zbits == 3'h0;
    endproperty
    a_unaligned_cfg: assert property (p_unaligned_cfg)
        else $error("unaligned counts wrong");
    property p_aligned_cfg;
        st.mode == MODE_ALIGNED |-> o_cfg_zbits == 3'h0 &&
            (o_cfg_err || (o_cfg_octets >= `PTM_OCT_MIN &&
                           o_cfg_octets <= `PTM_OCT_STRUCT));
    endproperty
    a_aligned_cfg: assert property (p_aligned_cfg)
        else $error("aligned counts wrong");
    property p_isdn_four;
        st.mode == MODE_ISDN && st.num == 3'h4
        |-> o_cfg_octets == `PTM_ISDN_OCT4 && o_cfg_zbits == `PTM_ISDN_Z4;
    endproperty
    a_isdn_four: assert property (p_isdn_four)
        else $error("four access counts wrong");
    property p_cfg_at_block;
        !bstart |=> $stable(st.mode) && $stable(o_cfg_octets);
    endproperty
    a_cfg_at_block: assert property (p_cfg_at_block)
        else $error("configuration changed inside block");
    property p_align_flag;
        i_slot_req && st.mode == MODE_ALIGNED && !bstart &&
        i_trib_frame_start
        |=> o_align_err ##1 (o_align_err || $past(i_err_clear));
    endproperty
    a_align_flag: assert property (p_align_flag)
        else $error("misaligned frame not flagged");
    property p_d_delay;
        bstart && i_mode == MODE_ISDN && i_num_access == 3'h1
        ##1 i_slot_req && !i_block_start
        |=> o_pay_bit == $past(st.d_cur[0][0]);
    endproperty
    a_d_delay: assert property (p_d_delay)
        else $error("d bit not delayed one block");
    property p_lifeline_b1;
        i_slot_req && !bstart && st.mode == MODE_ISDN &&
        st.num == 3'h2 && cur_pos == POS_W'(st.zb)
        |=> o_pay_bit == $past(st.b1[0][7]);
    endproperty
    a_lifeline_b1: assert property (p_lifeline_b1)
        else $error("access 1 b1 not in octet 1");
    property p_shared_d;
        i_slot_req && !bstart && st.mode == MODE_ISDN &&
        st.num == 3'h4 && cur_pos == POS_W'(2)
        |=> o_pay_bit == $past(st.d_cur[1][1]);
    endproperty
    a_shared_d: assert property (p_shared_d)
        else $error("access 2 d bit not in octet 1 bit 3");
endmodule // payload_tributary_mapper

// ==== shared/ptm_pkg.sv ====
package ptm_pkg;
    // mapping modes
    typedef enum logic [1:0] {
        MODE_CLEAR,
        MODE_UNALIGNED,
        MODE_ALIGNED,
        MODE_ISDN
    } map_mode_e;
endpackage

// ==== shared/ptm_regs.svh ====
`ifndef PTM_REGS_SVH
`define PTM_REGS_SVH
// payload block geometry
`define PTM_OCT_MIN    6'h03
`define PTM_OCT_MAX    6'h24
`define PTM_OCT_STRUCT 6'h20
`define PTM_ACC_MAX    3'h5
// octet and single-bit slot counts per number of basic accesses
`define PTM_ISDN_OCT1  6'h02
`define PTM_ISDN_OCT2  6'h04
`define PTM_ISDN_OCT3  6'h06
`define PTM_ISDN_OCT4  6'h09
`define PTM_ISDN_OCT5  6'h0b
`define PTM_ISDN_Z1    3'h2
`define PTM_ISDN_Z2    3'h4
`define PTM_ISDN_Z3    3'h6
`define PTM_ISDN_Z4    3'h0
`define PTM_ISDN_Z5    3'h2
// from this many accesses on, d channels share octet slot 1
`define PTM_SHARED_MIN 3'h4
`endif

// ==== verification/ptm_builder_model.sv ====
`timescale 1ns/1ns
// ---------------------------------------------
// line frame builder model
// ---------------------------------------------
module ptm_builder_model (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    // block command
    input  wire logic       i_go,
    input  wire logic [8:0] i_len,
    input  wire logic       i_slow,
    // slot requests
    output logic            o_req = 1'b0,
    output logic            o_bstart = 1'b0,
    output logic [8:0]      o_idx = 9'h000,
    output logic            o_busy = 1'b0
);
    logic [8:0] left;

    // one shared clock
    // one block of slot requests, a gap after each when slow
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_req <= 1'b0;
            o_bstart <= 1'b0;
            o_busy <= 1'b0;
        end else if (i_go) begin
            o_req <= 1'b1;
            o_bstart <= 1'b1;
            o_idx <= 9'h000;
            left <= i_len - 9'h001;
            o_busy <= 1'b1;
        end else if (o_busy) begin
            if (o_req && (left == 9'h000 || i_slow)) begin
                o_req <= 1'b0;
                o_bstart <= 1'b0;
                o_busy <= (left != 9'h000);
            end else begin
                o_req <= 1'b1;
                o_bstart <= 1'b0;
                o_idx <= o_idx + 9'h001;
                left <= left - 9'h001;
            end
        end
    end
endmodule // ptm_builder_model

// ==== verification/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
    import ptm_pkg::*;
    localparam int OCT [1:5] = '{2, 4, 6, 9, 11};
    localparam int ZB [1:5] = '{2, 4, 6, 0, 2};
    logic i_clk, i_rst_n, i_err_clear, i_slot_req, i_block_start;
    logic i_trib_bit, i_trib_frame_start, go, slow, busy;
    map_mode_e i_mode;
    logic [5:0] i_clr_octets, i_frac_octets, o_cfg_octets;
    logic [2:0] i_clr_zbits, i_num_access, o_cfg_zbits;
    logic [4:0][7:0] i_isdn_b1, i_isdn_b2;
    logic [4:0][1:0] i_isdn_d;
    logic o_pay_bit, o_pay_valid, o_cfg_err, o_align_err;
    logic [8:0] len, idx, fs_pos;
    logic [15:0] pat = 16'h4d2b;
    logic got[$], exp_q[$];
    int bad_count, checks;
    // ---------------------------------------------
    // design, builder and tributary source
    // ---------------------------------------------
    payload_tributary_mapper dut_u (.i_clk, .i_rst_n, .i_mode,
        .i_clr_octets, .i_clr_zbits, .i_frac_octets, .i_num_access,
        .i_err_clear, .i_slot_req, .i_block_start, .i_trib_bit,
        .i_trib_frame_start, .i_isdn_b1, .i_isdn_b2, .i_isdn_d,
        .o_pay_bit, .o_pay_valid, .o_cfg_octets, .o_cfg_zbits,
        .o_cfg_err, .o_align_err);
    ptm_builder_model bld_u (.i_clk, .i_rst_n, .i_go(go), .i_len(len),
        .i_slow(slow), .o_req(i_slot_req), .o_bstart(i_block_start),
        .o_idx(idx), .o_busy(busy));
    assign i_trib_bit = pat[idx[3:0]];
    assign i_trib_frame_start = i_slot_req && (idx == fs_pos);
    // collect payload answers
    always @(negedge i_clk)
        if (o_pay_valid === 1'b1) got.push_back(o_pay_bit);
    // ---------------------------------------------
    // helpers
    // ---------------------------------------------
    task automatic chk(input logic ok, input string m);
        checks++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    task automatic run_block(input logic [8:0] n, input logic sl);
        int t;
        got.delete();
        @(posedge i_clk);
        len <= n;
        slow <= sl;
        go <= 1'b1;
        @(posedge i_clk);
        go <= 1'b0;
        @(negedge i_clk);
        for (t = 0; t < 1000 && busy; t++) @(negedge i_clk);
        chk(busy === 1'b0, "block did not end");
        repeat (2) @(posedge i_clk);
    endtask
    task automatic cmp_bits(input string m);
        int e;
        e = (got.size() != exp_q.size());
        foreach (exp_q[k]) if (k < got.size() && got[k] !== exp_q[k]) e++;
        chk(e == 0, m);
    endtask
    task automatic stream_exp(input int n);
        exp_q.delete();
        for (int k = 0; k < n; k++) exp_q.push_back(pat[k % 16]);
    endtask
    task automatic isdn_exp(input int na);
        logic [7:0] s [1:11];
        logic z [1:7];
        logic [1:0] dp [0:4];
        int o;
        for (int k = 1; k <= 11; k++) s[k] = 8'h00;
        for (int k = 1; k <= 7; k++) z[k] = 1'b0;
        for (int a = 0; a < 5; a++) dp[a] = 2'(a + 1);
        o = (na == 5) ? 1 : 0;
        for (int k = 1; k <= na; k++) begin
            s[2*k-o*0-((na < 4) ? 1 : 0)] = i_isdn_b1[k-1];
            s[2*k+((na < 4) ? 0 : 1)] = i_isdn_b2[k-1];
            if (na < 4) {z[2*k-1], z[2*k]} = dp[k-1];
        end
        if (na == 5) {z[1], z[2]} = dp[0];
        if (na >= 4) for (int j = 1; j <= 4; j++)
            {s[1][9-2*j], s[1][8-2*j]} = dp[j-1+o];
        exp_q.delete();
        for (int k = 1; k <= ZB[na]; k++) exp_q.push_back(z[k]);
        for (int k = 1; k <= OCT[na]; k++)
            for (int j = 7; j >= 0; j--) exp_q.push_back(s[k][j]);
    endtask
    task automatic summarize();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ---------------------------------------------
    // scenarios
    // ---------------------------------------------
    task automatic test_clear();
        i_mode <= MODE_CLEAR;
        i_clr_octets <= 6'h03;
        i_clr_zbits <= 3'h5;
        run_block(9'd29, 1'b0);
        stream_exp(29);
        cmp_bits("clear bits");
        chk(o_cfg_octets === 6'h03 && o_cfg_zbits === 3'h5, "counts");
        i_clr_octets <= 6'h04;
        repeat (3) @(posedge i_clk);
        chk(o_cfg_octets === 6'h03, "counts moved outside block");
        run_block(9'd37, 1'b1);
        stream_exp(37);
        cmp_bits("slow clear bits");
        chk(o_cfg_octets === 6'h04, "counts not taken");
        $display("test clear done");
    endtask
    task automatic test_aligned();
        logic [5:0] f [2] = '{6'h03, 6'h20};
        i_mode <= MODE_ALIGNED;
        fs_pos <= 9'd0;
        foreach (f[k]) begin
            i_frac_octets <= f[k];
            run_block({f[k], 3'b000}, 1'b0);
            stream_exp(8 * f[k]);
            cmp_bits("aligned bits");
            chk(o_cfg_octets === f[k] && o_cfg_zbits === 3'h0, "al cnt");
            chk(o_align_err === 1'b0, "aligned false error");
        end
        fs_pos <= 9'd5;
        run_block(9'd24, 1'b0);
        chk(o_align_err === 1'b1, "aligned shift missed");
        i_err_clear <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_err_clear <= 1'b0;
        @(posedge i_clk);
        chk(o_align_err === 1'b0, "error not cleared");
        $display("test aligned done");
    endtask
    task automatic test_unaligned();
        i_mode <= MODE_UNALIGNED;
        fs_pos <= 9'd7;
        repeat (2) run_block(9'd256, 1'b0);
        stream_exp(256);
        cmp_bits("unaligned bits");
        chk(o_cfg_octets === 6'h20 && o_cfg_zbits === 3'h0, "un cnt");
        chk(o_align_err === 1'b0, "fixed offset flagged");
        fs_pos <= 9'd9;
        run_block(9'd256, 1'b0);
        chk(o_align_err === 1'b1, "moved offset missed");
        $display("test unaligned done");
    endtask
    task automatic test_isdn();
        i_mode <= MODE_ISDN;
        for (int na = 1; na <= 5; na++) begin
            i_num_access <= 3'(na);
            for (int a = 0; a < 5; a++) i_isdn_d[a] <= 2'(a + 1);
            run_block(9'(ZB[na] + 8 * OCT[na]), 1'b0);
            for (int a = 0; a < 5; a++) i_isdn_d[a] <= ~2'(a + 1);
            run_block(9'(ZB[na] + 8 * OCT[na]), 1'b0);
            isdn_exp(na);
            cmp_bits("isdn slots");
            chk(o_cfg_octets === 6'(OCT[na]) &&
                o_cfg_zbits === 3'(ZB[na]), "isdn counts");
        end
        i_num_access <= 3'h6;
        run_block(9'd8, 1'b0);
        chk(o_cfg_err === 1'b1, "six accesses taken");
        i_mode <= MODE_CLEAR;
        i_clr_octets <= 6'h02;
        run_block(9'd8, 1'b0);
        chk(o_cfg_err === 1'b1, "two octets taken");
        i_clr_octets <= 6'h24;
        run_block(9'd8, 1'b0);
        chk(o_cfg_err === 1'b0, "36 octets refused");
        $display("test isdn done");
    endtask
    // ---------------------------------------------
    // clock, reset, sequence and watchdog
    // ---------------------------------------------
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    initial begin
        {i_rst_n, go, slow, i_err_clear} = 4'h0;
        i_mode = MODE_CLEAR;
        {i_clr_octets, i_clr_zbits} = '0;
        {i_frac_octets, i_num_access, len, fs_pos} = '0;
        i_isdn_d = '0;
        for (int a = 0; a < 5; a++) begin
            i_isdn_b1[a] = 8'(8'h1e * (a + 1));
            i_isdn_b2[a] = 8'h81 ^ 8'(a * 9);
        end
        repeat (16) @(posedge i_clk);
        i_rst_n <= 1'b1;
        test_clear();
        test_aligned();
        test_unaligned();
        test_isdn();
        summarize();
    end
    initial begin
        repeat (20000) @(posedge i_clk);
        bad_count++;
        summarize();
    end
endmodule // tb_top
